/* design/cnsf_defines.svh */
// Purpose: constants for the node status flag block
// Assumes: included by bare name from design files
// Notes:   offsets are byte addresses on a 32-bit bus
`ifndef CNSF_DEFINES_SVH
`define CNSF_DEFINES_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CNSF_OFS_CSR          4'h0
`define CNSF_OFS_ERRCNT       4'h4

// ----------------------------------------------------------------
// control and status word and error count word fields
// ----------------------------------------------------------------
`define CNSF_BIT_HALT         0
`define CNSF_BIT_IRQ_EN       2
`define CNSF_BIT_STATE_LO     8
`define CNSF_BIT_STATE_HI     9
`define CNSF_BIT_FLAG         10
`define CNSF_BIT_RX_ACT       14
`define CNSF_BIT_TX_ACT       15
`define CNSF_ERR_TX_LSB       0
`define CNSF_ERR_RX_LSB       16

// ----------------------------------------------------------------
// node state codes
// ----------------------------------------------------------------
`define CNSF_NS_ACTIVE        2'h0
`define CNSF_NS_WARNING       2'h1
`define CNSF_NS_PASSIVE       2'h2
`define CNSF_NS_BUSOFF        2'h3

// ----------------------------------------------------------------
// reset values and thresholds
// ----------------------------------------------------------------
`define CNSF_RST_HALT         1'b1
`define CNSF_RST_IRQ_EN       1'b0
`define CNSF_LIM_WARNING      9'h060
`define CNSF_LIM_PASSIVE      9'h080
`define CNSF_LIM_BUSOFF       9'h100
`define CNSF_RECESSIVE_BITS   11
`define CNSF_BUSOFF_SEQS      128

`endif

/* design/cnsf_pkg.sv */
// Purpose: types shared by the node status flag block
// Assumes: nothing beyond the defines header
// Notes:   numeric constants live in cnsf_defines.svh
package cnsf_pkg;

    typedef logic [1:0] cnsf_node_code_type;

    typedef enum logic [1:0] {
        REC_IDLE,
        REC_COUNT,
        REC_DONE
    } cnsf_rec_state_type;

endpackage : cnsf_pkg

/* design/cnsf_recovery.sv */
// Purpose: counts runs of recessive bits before the bus is rejoined
// Assumes: bit_tick_i marks one sample point per bit time
// Notes:   a dominant bit restarts the current run only
`timescale 1ns/1ns

module cnsf_recovery
    import cnsf_pkg::*;
#(
    parameter int RUN_BITS = 11,
    parameter int MAX_RUNS = 128
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // control
    input  wire logic         start_i,
    input  wire logic         busoff_i,
    // bus sampling
    input  wire logic         bit_tick_i,
    input  wire logic         rx_i,
    // result
    output logic              done_o
);

    localparam int BW = $clog2(RUN_BITS + 1);
    localparam int RW = $clog2(MAX_RUNS + 1);

    cnsf_rec_state_type state_r;
    logic [BW-1:0]      bits_r;
    logic [RW-1:0]      runs_r;
    logic [RW-1:0]      need_r;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= REC_IDLE;
            bits_r  <= '0;
            runs_r  <= '0;
            need_r  <= RW'(1);
        end else begin
            unique case (state_r)
                REC_IDLE: begin
                    bits_r <= '0;
                    runs_r <= '0;
                    if (start_i) begin
                        need_r  <= busoff_i ? RW'(MAX_RUNS) : RW'(1);
                        state_r <= REC_COUNT;
                    end
                end
                REC_COUNT: begin
                    if (bit_tick_i) begin
                        if (!rx_i) begin
                            bits_r <= '0;
                        end else if (bits_r == BW'(RUN_BITS - 1)) begin
                            bits_r <= '0;
                            runs_r <= runs_r + RW'(1);
                            if (runs_r + RW'(1) == need_r) begin
                                state_r <= REC_DONE;
                            end
                        end else begin
                            bits_r <= bits_r + BW'(1);
                        end
                    end
                end
                REC_DONE: begin
                    state_r <= REC_IDLE;
                end
                default: begin
                    state_r <= REC_IDLE;
                end
            endcase
        end
    end

    assign done_o = (state_r == REC_DONE);

endmodule : cnsf_recovery

/* design/cnsf_status.sv */
// Purpose: node state, transition flag and activity bits of the
//          control and status word, behind a classic wishbone slave
// Assumes: protocol engine supplies error counts, frame tracking
//          and a bit sample strobe, all synchronous to clk_i
// Notes:   one 32-bit register word per offset
`timescale 1ns/1ns
`include "cnsf_defines.svh"

module cnsf_status
    import cnsf_pkg::*;
#(
    parameter int RUN_BITS = `CNSF_RECESSIVE_BITS,
    parameter int MAX_RUNS = `CNSF_BUSOFF_SEQS
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // wishbone slave
    input  wire logic         cyc_i,
    input  wire logic         stb_i,
    input  wire logic         we_i,
    input  wire logic         lock_i,
    input  wire logic [3:0]   adr_i,
    input  wire logic [3:0]   sel_i,
    input  wire logic [31:0]  dat_i,
    output logic [31:0]       dat_o,
    output logic              ack_o,
    // error counters from protocol engine
    input  wire logic [8:0]   tx_err_cnt_i,
    input  wire logic [7:0]   rx_err_cnt_i,
    // bus frame tracking
    input  wire logic         msg_on_bus_i,
    input  wire logic         err_ovl_on_bus_i,
    input  wire logic         intermission_i,
    input  wire logic         bus_idle_i,
    input  wire logic         node_tx_msg_i,
    input  wire logic         node_tx_err_ovl_i,
    // bus sampling
    input  wire logic         bit_tick_i,
    input  wire logic         rx_i,
    // status toward the controller
    output logic [1:0]        node_state_o,
    output logic              rx_active_o,
    output logic              tx_active_o,
    output logic              halt_o,
    output logic              err_cnt_clear_o,
    output logic              state_change_irq_o
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic                 ack_r;
    logic [31:0]          dat_r;
    logic                 req;
    logic                 wr_en;
    logic                 rd_en;
    logic                 hit_csr;
    logic                 hit_err;
    logic                 wr_csr_hi;
    logic                 wr_csr_lo;

    cnsf_node_code_type   node_state_r;
    cnsf_node_code_type   node_state_nxt;
    cnsf_node_code_type   raw_state;
    logic                 transition;

    logic                 flag_r;
    logic                 flag_nxt;
    logic                 irq_en_r;
    logic                 halt_r;
    logic                 halt_nxt;
    logic                 rx_active_r;
    logic                 tx_active_r;
    logic                 clear_r;

    logic                 rec_start;
    logic                 rec_done;
    logic                 rec_busy_r;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    assign req       = cyc_i && stb_i;
    // writes land on the edge that also shows ack to the master
    assign wr_en     = req && we_i && ack_r;
    // reads load one cycle early so the data stands with ack
    assign rd_en     = req && !we_i && !ack_r;
    // unmapped offsets still ack and read as zero
    assign hit_csr   = (adr_i == `CNSF_OFS_CSR);
    assign hit_err   = (adr_i == `CNSF_OFS_ERRCNT);
    assign wr_csr_hi = wr_en && hit_csr && sel_i[1];
    assign wr_csr_lo = wr_en && hit_csr && sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            // drop ack in the cycle after it was given
            ack_r <= req && !ack_r;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (rd_en) begin
            dat_r <= 32'h0000_0000;
            if (hit_csr) begin
                dat_r[`CNSF_BIT_HALT]     <= halt_r;
                dat_r[`CNSF_BIT_IRQ_EN]   <= irq_en_r;
                dat_r[`CNSF_BIT_STATE_LO] <= node_state_r[0];
                dat_r[`CNSF_BIT_STATE_HI] <= node_state_r[1];
                // locked read sees 1 so its write-back cannot clear
                dat_r[`CNSF_BIT_FLAG]     <= flag_r || lock_i;
                dat_r[`CNSF_BIT_RX_ACT]   <= rx_active_r;
                dat_r[`CNSF_BIT_TX_ACT]   <= tx_active_r;
            end else if (hit_err) begin
                dat_r[`CNSF_ERR_TX_LSB +: 9] <= tx_err_cnt_i;
                dat_r[`CNSF_ERR_RX_LSB +: 8] <= rx_err_cnt_i;
            end
        end else if (!req) begin
            dat_r <= 32'h0000_0000;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // ----------------------------------------------------------------
    // node state from the error counters
    // ----------------------------------------------------------------
    // thresholds compare the full nine-bit transmit count
    always_comb begin
        if (tx_err_cnt_i >= `CNSF_LIM_BUSOFF) begin
            raw_state = `CNSF_NS_BUSOFF;
        end else if (tx_err_cnt_i >= `CNSF_LIM_PASSIVE
                     || {1'b0, rx_err_cnt_i} >= `CNSF_LIM_PASSIVE) begin
            raw_state = `CNSF_NS_PASSIVE;
        end else if (tx_err_cnt_i >= `CNSF_LIM_WARNING
                     || {1'b0, rx_err_cnt_i} >= `CNSF_LIM_WARNING) begin
            raw_state = `CNSF_NS_WARNING;
        end else begin
            raw_state = `CNSF_NS_ACTIVE;
        end
    end

    always_comb begin
        node_state_nxt = node_state_r;
        if (node_state_r == `CNSF_NS_BUSOFF) begin
            // bus off is left only through the recovery sequence
            if (rec_done) begin
                node_state_nxt = `CNSF_NS_ACTIVE;
            end
        end else if (clear_r) begin
            // counters are zeroed on this edge; judging the stale
            // counts here would throw the node straight back to bus off
            node_state_nxt = node_state_r;
        end else begin
            node_state_nxt = raw_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            node_state_r <= `CNSF_NS_ACTIVE;
        end else begin
            node_state_r <= node_state_nxt;
        end
    end

    assign node_state_o = node_state_r;

    // ----------------------------------------------------------------
    // transition flag
    // ----------------------------------------------------------------
    // only the four forward steps of the cycle count as transitions
    always_comb begin
        transition = 1'b0;
        unique case (node_state_r)
            `CNSF_NS_ACTIVE:  transition = (node_state_nxt == `CNSF_NS_WARNING);
            `CNSF_NS_WARNING: transition = (node_state_nxt == `CNSF_NS_PASSIVE);
            `CNSF_NS_PASSIVE: transition = (node_state_nxt == `CNSF_NS_BUSOFF);
            `CNSF_NS_BUSOFF:  transition = (node_state_nxt == `CNSF_NS_ACTIVE);
        endcase
    end

    always_comb begin
        flag_nxt = flag_r;
        if (wr_csr_hi && !dat_i[`CNSF_BIT_FLAG]) begin
            flag_nxt = 1'b0;
        end
        // writing 1 falls through and keeps the flag as it is
        // placed last so a transition beats a same-cycle clear
        if (transition) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // ----------------------------------------------------------------
    // low byte controls
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en_r <= `CNSF_RST_IRQ_EN;
        end else if (wr_csr_lo) begin
            irq_en_r <= dat_i[`CNSF_BIT_IRQ_EN];
        end
    end

    // bits 11..13 have no storage, so writes there vanish

    always_comb begin
        halt_nxt = halt_r;
        if (wr_csr_lo) begin
            // writing 1 halts at once; writing 0 only arms recovery,
            // so halt stays up until the recessive runs are counted
            halt_nxt = halt_r || dat_i[`CNSF_BIT_HALT];
        end
        if (rec_done) begin
            halt_nxt = 1'b0;
        end
        if (node_state_nxt == `CNSF_NS_BUSOFF
            && node_state_r != `CNSF_NS_BUSOFF) begin
            halt_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            halt_r <= `CNSF_RST_HALT;
        end else begin
            halt_r <= halt_nxt;
        end
    end

    assign halt_o = halt_r;

    // ----------------------------------------------------------------
    // recovery toward the bus
    // ----------------------------------------------------------------
    // a write of 0 to a set halt bit arms the recessive run counter
    assign rec_start = wr_csr_lo && halt_r && !dat_i[`CNSF_BIT_HALT]
                       && !rec_busy_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rec_busy_r <= 1'b0;
        end else if (rec_done) begin
            rec_busy_r <= 1'b0;
        end else if (rec_start) begin
            rec_busy_r <= 1'b1;
        end
    end

    cnsf_recovery #(
        .RUN_BITS (RUN_BITS),
        .MAX_RUNS (MAX_RUNS)
    ) u_recovery (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .start_i    (rec_start),
        .busoff_i   (node_state_r == `CNSF_NS_BUSOFF),
        .bit_tick_i (bit_tick_i),
        .rx_i       (rx_i),
        .done_o     (rec_done)
    );

    // counters are zeroed only when bus off is left
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_r <= 1'b0;
        end else begin
            clear_r <= rec_done && node_state_r == `CNSF_NS_BUSOFF;
        end
    end

    assign err_cnt_clear_o = clear_r;

    // ----------------------------------------------------------------
    // activity indicators
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_active_r <= 1'b0;
        end else begin
            // own transmissions count too; filtering plays no part
            rx_active_r <= msg_on_bus_i
                           && !err_ovl_on_bus_i
                           && !halt_r && !intermission_i && !bus_idle_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_active_r <= 1'b0;
        end else begin
            tx_active_r <= node_tx_msg_i
                           && !node_tx_err_ovl_i && !halt_r;
        end
    end

    assign rx_active_o = rx_active_r;
    assign tx_active_o = tx_active_r;

    // ----------------------------------------------------------------
    // interrupt request
    // ----------------------------------------------------------------
    // plain level; the flag gated by irq_en_r, no sticky logic beyond the flag
    assign state_change_irq_o = flag_r && irq_en_r;

endmodule : cnsf_status

/* verif/cnsf_status_props.sv */
// Purpose: port checks for the node status block
// Assumes: one clock, synchronous reset
// Notes:   flag is seen only through the irq output
`timescale 1ns/1ns

module cnsf_status_chk (
    // clock, reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // bus
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       we_i,
    input wire logic       ack_o,
    // frames
    input wire logic       msg_on_bus_i,
    input wire logic       err_ovl_on_bus_i,
    input wire logic       intermission_i,
    input wire logic       bus_idle_i,
    input wire logic       node_tx_msg_i,
    input wire logic       node_tx_err_ovl_i,
    // status
    input wire logic [1:0] node_state_o,
    input wire logic       rx_active_o,
    input wire logic       tx_active_o,
    input wire logic       halt_o,
    input wire logic       err_cnt_clear_o,
    input wire logic       state_change_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // 11 to 00 wraps, so one step covers all four setting moves
    sequence fwd_step_s;
        node_state_o == $past(node_state_o) + 2'h1;
    endsequence
    sequence busoff_exit_s;
        $past(node_state_o) == 2'h3 && node_state_o == 2'h0;
    endsequence

    ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    rx_msg_a: assert property (msg_on_bus_i && !err_ovl_on_bus_i && !intermission_i
        && !bus_idle_i && !halt_o |=> rx_active_o) else $error("rx activity missing");
    rx_errfrm_a: assert property (err_ovl_on_bus_i |=> !rx_active_o)
        else $error("rx activity in error frame");
    rx_quiet_a: assert property (intermission_i || bus_idle_i |=> !rx_active_o)
        else $error("rx activity on quiet bus");
    rx_halt_a: assert property (halt_o |=> !rx_active_o)
        else $error("rx activity while halted");
    tx_msg_a: assert property (node_tx_msg_i && !node_tx_err_ovl_i |=> tx_active_o)
        else $error("tx activity missing");
    tx_errfrm_a: assert property (node_tx_err_ovl_i |=> !tx_active_o)
        else $error("tx activity in error frame");
    irq_cause_a: assert property ($rose(state_change_irq_o) |-> fwd_step_s or $past(ack_o && we_i))
        else $error("irq rose without cause");
    busoff_exit_a: assert property (busoff_exit_s |-> ##[0:2] err_cnt_clear_o)
        else $error("no counter clear on leaving bus off");
    clr_pulse_a: assert property (err_cnt_clear_o |=> !err_cnt_clear_o)
        else $error("counter clear too long");
endmodule : cnsf_status_chk

bind cnsf_status cnsf_status_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o,
    .msg_on_bus_i, .err_ovl_on_bus_i, .intermission_i, .bus_idle_i, .node_tx_msg_i,
    .node_tx_err_ovl_i, .node_state_o, .rx_active_o, .tx_active_o, .halt_o,
    .err_cnt_clear_o, .state_change_irq_o);

/* verif/cnsf_bus_model.sv */
// Purpose: protocol engine and bus seen from the status block
// Assumes: frame kind and transmit count chosen by the bench
// Notes:   0 idle, 1 rx msg, 2 own msg, 3 err, 4 own err, 5 gap
`timescale 1ns/1ns

module cnsf_bus_model (
    // clock, reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // bench control
    input  wire logic [2:0] frame_i,
    input  wire logic       load_i,
    input  wire logic [8:0] tx_ld_i,
    input  wire logic       clear_i,
    // toward the block
    output logic [8:0]      tx_err_cnt_o,
    output logic [7:0]      rx_err_cnt_o,
    output logic            msg_on_bus_o,
    output logic            err_ovl_on_bus_o,
    output logic            intermission_o,
    output logic            bus_idle_o,
    output logic            node_tx_msg_o,
    output logic            node_tx_err_ovl_o,
    output logic            bit_tick_o,
    output logic            rx_o
);
    logic [1:0] ph_r;

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            tx_err_cnt_o <= 9'h000;
            rx_err_cnt_o <= 8'h00;
        end else if (load_i) begin
            tx_err_cnt_o <= tx_ld_i;
        end
    end

    always_ff @(posedge clk_i) begin
        ph_r <= rst_i ? 2'h0 : ph_r + 2'h1;
    end

    assign bit_tick_o        = ph_r[0];
    assign bus_idle_o        = frame_i == 3'h0;
    assign msg_on_bus_o      = frame_i == 3'h1 || frame_i == 3'h2;
    assign node_tx_msg_o     = frame_i == 3'h2;
    assign err_ovl_on_bus_o  = frame_i == 3'h3 || frame_i == 3'h4;
    assign node_tx_err_ovl_o = frame_i == 3'h4;
    assign intermission_o    = frame_i == 3'h5;
    // frames alternate levels at sample points, so no run completes
    assign rx_o              = bus_idle_o || intermission_o || ph_r[1];
endmodule : cnsf_bus_model

/* verif/tb_cnsf_status.sv */
// Purpose: register and status scenarios for the node status block
// Assumes: two recovery runs instead of 128 to keep the run short
// Notes:   bus transfers are classic single wishbone cycles
`timescale 1ns/1ns

module tb_cnsf_status import cnsf_pkg::*;;
    localparam logic [8:0] TX_TAB [3] = '{9'h060, 9'h080, 9'h100};
    localparam logic [4:0] RX_TAB     = 5'h03;
    localparam logic [4:0] TX_ACT     = 5'h02;
    logic        clk_i = 1'b0, rst_i = 1'b1, load = 1'b0, seen_clr = 1'b0;
    logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, lock_i = 1'b0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
    logic [8:0]  tx_ld = 9'h000, tx_err_cnt_i;
    logic [7:0]  rx_err_cnt_i;
    logic [2:0]  frame = 3'h0;
    logic [1:0]  node_state_o;
    logic        ack_o, halt_o, rx_active_o, tx_active_o, err_cnt_clear_o, state_change_irq_o;
    logic        msg_on_bus_i, err_ovl_on_bus_i, intermission_i, bus_idle_i;
    logic        node_tx_msg_i, node_tx_err_ovl_i, bit_tick_i, rx_i;
    int          failures = 0, compares = 0;

    cnsf_status #(.RUN_BITS(11), .MAX_RUNS(2)) DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
        .lock_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .tx_err_cnt_i, .rx_err_cnt_i,
        .msg_on_bus_i, .err_ovl_on_bus_i, .intermission_i, .bus_idle_i, .node_tx_msg_i,
        .node_tx_err_ovl_i, .bit_tick_i, .rx_i, .node_state_o, .rx_active_o, .tx_active_o,
        .halt_o, .err_cnt_clear_o, .state_change_irq_o);
    cnsf_bus_model u_bus (.clk_i, .rst_i, .frame_i(frame), .load_i(load), .tx_ld_i(tx_ld),
        .clear_i(err_cnt_clear_o), .tx_err_cnt_o(tx_err_cnt_i), .rx_err_cnt_o(rx_err_cnt_i),
        .msg_on_bus_o(msg_on_bus_i), .err_ovl_on_bus_o(err_ovl_on_bus_i),
        .intermission_o(intermission_i), .bus_idle_o(bus_idle_i),
        .node_tx_msg_o(node_tx_msg_i), .node_tx_err_ovl_o(node_tx_err_ovl_i),
        .bit_tick_o(bit_tick_i), .rx_o(rx_i));

    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) if (err_cnt_clear_o === 1'b1) seen_clr <= 1'b1;

    task automatic conclude();
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d, input logic lk, output logic [31:0] rd);
        int n;
        cyc_i  <= 1'b1;
        stb_i  <= 1'b1;
        we_i   <= w;
        adr_i  <= a;
        sel_i  <= s;
        dat_i  <= d;
        lock_i <= lk;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            failures++;
            conclude();
        end
        rd = dat_o;
        cyc_i  <= 1'b0;
        stb_i  <= 1'b0;
        we_i   <= 1'b0;
        lock_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wait_run();
        int n;
        n = 0;
        while (halt_o !== 1'b0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (halt_o !== 1'b0) begin
            failures++;
            conclude();
        end
        repeat (3) @(posedge clk_i);
    endtask : wait_run

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 4'h0, 4'hf, 32'h0000_0000, 1'b0, q);
        chk("csr reset", q, 32'h0000_0001);
        wb(1'b0, 4'h8, 4'hf, 32'h0000_0000, 1'b0, q);
        chk("unmapped", q, 32'h0000_0000);
        // write of the low two bytes, never a bitwise rmw of the low byte
        wb(1'b1, 4'h0, 4'h3, 32'h0000_3c04, 1'b0, q);
        wait_run();
        wb(1'b0, 4'h0, 4'hf, 32'h0000_0000, 1'b0, q);
        chk("csr released", q, 32'h0000_0004);
        for (int k = 1; k < 6; k++) begin
            frame <= 3'(k);
            repeat (3) @(posedge clk_i);
            chk("rx active", 32'(rx_active_o), 32'(RX_TAB[k-1]));
            chk("tx active", 32'(tx_active_o), 32'(TX_ACT[k-1]));
            if (k == 2) begin
                wb(1'b0, 4'h0, 4'hf, 32'h0000_0000, 1'b0, q);
                chk("csr busy", q, 32'h0000_c004);
            end
        end
        frame <= 3'h0;
        for (int k = 0; k < 3; k++) begin
            tx_ld <= TX_TAB[k];
            load  <= 1'b1;
            if (k == 1) begin
                // the transition and the clear land on the same edge
                wb(1'b1, 4'h0, 4'h2, 32'h0000_0000, 1'b0, q);
                chk("set beats clear", 32'(state_change_irq_o), 32'h1);
            end else begin
                @(posedge clk_i);
            end
            load  <= 1'b0;
            repeat (3) @(posedge clk_i);
            chk("node state", 32'(node_state_o), k + 1);
            chk("irq set", 32'(state_change_irq_o), 32'h1);
            if (k == 0) begin
                wb(1'b0, 4'h4, 4'hf, 32'h0000_0000, 1'b0, q);
                chk("err counts", q, 32'h0000_0060);
                wb(1'b1, 4'h0, 4'h2, 32'h0000_0400, 1'b0, q);
                chk("irq kept", 32'(state_change_irq_o), 32'h1);
            end
            wb(1'b1, 4'h0, 4'h2, 32'h0000_0000, 1'b0, q);
            chk("irq cleared", 32'(state_change_irq_o), 32'h0);
            wb(1'b0, 4'h0, 4'hf, 32'h0000_0000, 1'b1, q);
            chk("rmw flag", 32'(q[10]), 32'h1);
        end
        frame <= 3'h1;
        repeat (3) @(posedge clk_i);
        chk("rx halted", 32'(rx_active_o), 32'h0);
        frame <= 3'h0;
        wb(1'b1, 4'h0, 4'h1, 32'h0000_0004, 1'b0, q);
        wait_run();
        chk("state after off", 32'(node_state_o), 32'h0);
        chk("irq off exit", 32'(state_change_irq_o), 32'h1);
        chk("clear pulse", 32'(seen_clr), 32'h1);
        wb(1'b0, 4'h4, 4'hf, 32'h0000_0000, 1'b0, q);
        chk("counts zeroed", q, 32'h0000_0000);
        conclude();
    end
endmodule : tb_cnsf_status
